// ===== dv/sfep_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link, mode 0: sck idles low, every pin moves just after a clk_sys rise
module sfep_host import sfep_pkg::*; #(
  parameter int unsigned HALF = 6
) (
  input wire logic clk_sys,
  input wire logic so,
  input wire logic so_oe,
  output var sfep_pins_t pins
);
  logic last_bit = 1'b0;

  initial pins = PINS_RST;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // msb first; a released so reads as the inverse of its last level so it never matches by luck
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      pins.sck <= 1'b0;
      pins.si <= tx[i];
      tick(HALF);
      pins.sck <= 1'b1;
      tick(HALF);
      last_bit = so_oe ? so : ~last_bit;
      rx[i] = last_bit;
    end
  endtask

  task automatic frame_open();
    pins.cs_n <= 1'b0;
    tick(HALF);
  endtask

  // sck is brought low first so select always rises in mode 0 idle
  task automatic frame_close();
    pins.sck <= 1'b0;
    tick(HALF);
    pins.cs_n <= 1'b1;
    tick(2 * HALF);
  endtask

  // hold only moves while sck is low; clock and data wiggle meanwhile and must be ignored
  task automatic hold_gap(output logic seen);
    seen = 1'b0;
    pins.sck <= 1'b0;
    tick(HALF);
    pins.hold_n <= 1'b0;
    tick(HALF);
    repeat (4) begin
      pins.sck <= ~pins.sck;
      pins.si <= ~pins.si;
      tick(HALF);
      seen |= so_oe;
    end
    pins.hold_n <= 1'b1;
    tick(HALF);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import sfep_pkg::*;;
  localparam int CHE = 800;
  localparam int PP = 50;
  localparam int LIMIT = 30000;
  localparam logic [7:0] RDSR = 8'h05;
  localparam logic [7:0] WREN = 8'h06;
  localparam logic [7:0] WRDI = 8'h04;
  localparam logic [7:0] WRSR = 8'h01;
  localparam logic [7:0] PDN = 8'hb9;
  localparam logic [7:0] WAKE = 8'hab;
  localparam int SRW = 30;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic buf_rd_en = 1'b0;
  logic [7:0] buf_raddr = 8'h00;
  logic so, so_oe, erase_go, prog_go, op_busy, power_down, buf_rvalid, seen;
  logic [PAGE_BITS-1:0] prog_page;
  logic [7:0] buf_rdata, rx;
  logic [23:0] addr;
  logic [7:0] q[$];
  logic [7:0] erase_op[2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  logic [31:0] seed = 32'd78870;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0, n_erase = 0, n_prog = 0, n_busy = 0, n_oe = 0;
  sfep_pins_t pins;

  sfep_host sfep_host_i (.clk_sys(clk_sys), .so(so), .so_oe(so_oe), .pins(pins));
  sfep_top #(.CYC_CHE(CHE), .CYC_PP(PP), .CYC_SRW(SRW)) sfep_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .sck(pins.sck), .cs_n(pins.cs_n), .si(pins.si),
    .hold_n(pins.hold_n), .wp_n(pins.wp_n), .so(so), .so_oe(so_oe), .erase_go(erase_go),
    .prog_go(prog_go), .prog_page(prog_page), .op_busy(op_busy), .power_down(power_down),
    .buf_rd_en(buf_rd_en), .buf_raddr(buf_raddr), .buf_rdata(buf_rdata), .buf_rvalid(buf_rvalid));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters sample on the falling edge, where every registered output has settled
  always @(negedge clk_sys) begin
    cyc++;
    n_erase += int'(erase_go === 1'b1);
    n_prog += int'(prog_go === 1'b1);
    n_busy += int'(op_busy === 1'b1);
    n_oe += int'(so_oe === 1'b1);
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // identification bytes cycle maker, type, capacity, reserved
  function automatic logic [7:0] id_exp(input int i);
    logic [7:0] t[4] = '{8'h5a, 8'h11, 8'h12, 8'h00};
    return t[i % 4];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] b[$], input int tail = 0);
    sfep_host_i.frame_open();
    foreach (b[i]) sfep_host_i.xfer(b[i], 8, rx);
    if (tail > 0) sfep_host_i.xfer(8'h00, tail, rx);
    sfep_host_i.frame_close();
  endtask

  task automatic status(input logic [7:0] exp);
    frame('{RDSR, 8'h00});
    chk("status", 32'(exp), 32'(rx));
  endtask

  // the watchdog bounds this wait
  task automatic wait_idle();
    repeat (4) @(posedge clk_sys);
    while (op_busy !== 1'b0) @(posedge clk_sys);
  endtask

  task automatic buf_chk(input logic [7:0] col, input logic [7:0] exp);
    @(posedge clk_sys);
    buf_rd_en <= 1'b1;
    buf_raddr <= col;
    @(posedge clk_sys);
    buf_rd_en <= 1'b0;
    #1;
    chk("buffer", {23'h0, 1'b1, exp}, {23'h0, buf_rvalid, buf_rdata});
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("op_busy", 32'h0, 32'(op_busy));
    chk("power_down", 32'h0, 32'(power_down));
    // identification read across three rounds, suspended once in the middle
    sfep_host_i.frame_open();
    sfep_host_i.xfer(OP_READ_ID, 8, rx);
    for (int i = 0; i < 3 * ID_BYTES; i++) begin
      if (i == 5) begin
        sfep_host_i.hold_gap(seen);
        chk("so_oe in hold", 32'h0, 32'(seen));
      end
      sfep_host_i.xfer(rnd(), 8, rx);
      chk("id byte", 32'(id_exp(i)), 32'(rx));
    end
    sfep_host_i.frame_close();
    frame('{WREN});
    status(8'h02);
    frame('{WRDI});
    status(8'h00);
    // both erase codes; identification is refused while busy, status still answers
    foreach (erase_op[k]) begin
      frame('{WREN});
      n_erase = 0;
      n_busy = 0;
      frame('{erase_op[k]});
      n_oe = 0;
      frame('{OP_READ_ID, 8'h00, 8'h00});
      chk("so_oe id busy", 32'h0, 32'(n_oe));
      status(8'h03);
      wait_idle();
      chk("erase_go", 32'h1, 32'(n_erase));
      chk("busy span", 32'h1, 32'(n_busy >= CHE && n_busy <= CHE + 1));
      status(8'h00);
    end
    // program after the erase: column wraps inside the page, junk in the top address bits
    addr = {rnd(), rnd(), 8'hfe};
    q = {OP_PAGE_PROG, addr[23:16], addr[15:8], addr[7:0], rnd(), rnd(), rnd()};
    frame('{WREN});
    n_prog = 0;
    n_busy = 0;
    frame(q);
    wait_idle();
    chk("prog_go", 32'h1, 32'(n_prog));
    chk("prog_page", 32'(addr[17:8]), 32'(prog_page));
    chk("prog busy", 32'h1, 32'(n_busy >= PP));
    for (int i = 0; i < 3; i++) buf_chk(8'(addr[7:0] + 8'(i)), q[4 + i]);
    // a ragged end, then an overrun while the buffer side stalls: both are dropped
    for (int k = 0; k < 2; k++) begin
      frame('{WREN});
      n_prog = 0;
      if (k == 1) q = {q, rnd(), rnd(), rnd()};
      buf_rd_en <= (k == 1);
      frame(q, 3 * (1 - k));
      buf_rd_en <= 1'b0;
      wait_idle();
      chk("dropped prog", 32'h0, 32'(n_prog));
    end
    // status write: one data byte lands and clears the latch, a second data byte voids it
    for (int k = 0; k < 2; k++) begin
      frame('{WREN});
      n_busy = 0;
      if (k == 0) frame('{WRSR, 8'h3c});
      else frame('{WRSR, 8'hc0, 8'h00});
      wait_idle();
      if (k == 0) chk("srw busy", 32'h1, 32'(n_busy >= SRW && n_busy <= SRW + 1));
      else chk("srw long busy", 32'h0, 32'(n_busy));
      status(k == 0 ? 8'h3c : 8'h3e);
    end
    // power down only by its command; identification is refused until the wake code
    frame('{PDN});
    chk("power_down", 32'h1, 32'(power_down));
    n_oe = 0;
    frame('{OP_READ_ID, 8'h00});
    chk("so_oe power down", 32'h0, 32'(n_oe));
    frame('{WAKE});
    chk("power_down", 32'h0, 32'(power_down));
    close_out();
  end
endmodule
`default_nettype wire

// ===== hdl/sfep_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sfep_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // full and empty come straight from the fill count
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // pointers and count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= bump(wp_r);
      if (pop) rp_r <= bump(rp_r);
      cnt_r <= (PW+1)'(cnt_r + push - pop);
    end
  end

  // storage has no reset, it is only read when counted valid
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule
`default_nettype wire

// ===== hdl/sfep_pkg.sv
package sfep_pkg;

  // opcodes fixed by the command set
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_READ_ID = 8'h9f;

  ////////////////////////////////////////////////////////////////////////////
  // geometry and status layout
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned PAGE_BITS = 10;
  localparam int unsigned ID_BYTES = 4;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_WEL_BIT = 1;
  localparam int unsigned STATUS_LOCK_BIT = 7;
  localparam logic [5:0] STATUS_BITS_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // internal operation times and their cycle counts
  localparam real CLK_NS = 10.0;
  localparam real STATUS_WRITE_DURATION_MS = 10.0;
  localparam real PAGE_WRITE_DURATION_MS = 3.5;
  localparam real FULL_ERASE_DURATION_S = 3.0;
  localparam int unsigned SRW_CYC = int'($floor(STATUS_WRITE_DURATION_MS * 1.0e6 / CLK_NS));
  localparam int unsigned PP_CYC = int'($floor(PAGE_WRITE_DURATION_MS * 1.0e6 / CLK_NS));
  localparam int unsigned CHE_CYC = int'($floor(FULL_ERASE_DURATION_S * 1.0e9 / CLK_NS));
  localparam int unsigned FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } sfep_pins_t;

  // idle bus: deselected, hold released, not protected
  localparam sfep_pins_t PINS_RST = 5'b01011;

  typedef struct packed {
    logic [7:0] col;
    logic [7:0] data;
  } sfep_byte_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_OUT = 3'b011,
    ST_SRW = 3'b100,
    ST_SRW2 = 3'b101,
    ST_SKIP = 3'b110
  } sfep_state_t;

  typedef enum logic [2:0] {
    PEND_NONE = 3'b000,
    PEND_ERASE = 3'b001,
    PEND_PROG = 3'b010,
    PEND_SRW = 3'b011,
    PEND_WEN = 3'b100,
    PEND_WDIS = 3'b101,
    PEND_PD = 3'b110,
    PEND_WAKE = 3'b111
  } sfep_pend_t;

endpackage

// ===== hdl/sfep_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sfep_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire logic [31:0] cycles,
  output logic busy,
  output logic done
);
  logic [31:0] cnt_r;

  // busy spans exactly the loaded count; done marks its last cycle
  assign busy = (cnt_r != 32'h0000_0000);
  assign done = (cnt_r == 32'h0000_0001);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cnt_r <= 32'h0000_0000;
    else if (start) cnt_r <= cycles;
    else if (busy) cnt_r <= cnt_r - 32'h0000_0001;
  end
endmodule
`default_nettype wire

// ===== hdl/sfep_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - chip erase is one byte, 60h or c7h, with nothing after it
// - erase starts at chip select rise and ends by internal timer
// - busy flag in status set during erase, cleared when it ends
// - page program writes 1 to 256 bytes within page A17..A8
// - program is 02h, three address bytes msb first, then data
// - only address bits A17..A0 are used
// - id read ignored while an internal operation runs
// - 9fh returns maker code, type, capacity, reserved byte
// - id bytes repeat while chip select stays low
// - hold entered on hold fall with clock low, left on hold rise
// - hold only while selected; select rise ends hold, resets interface
// - in hold the output floats and clock and data are ignored
// - power up lands in standby; power down only by its command
// - write command dropped when select rises off a byte boundary
// - page program dropped when data is not whole bytes
// - status write longer than two bytes is rejected
// - status write takes at most 10 ms, busy throughout
// - page program takes at most 3.5 ms, busy throughout
// - chip erase takes at most 3.0 s, busy throughout
// - write enable latch clears when a write or erase finishes
// - write enable latch 0 forbids writes; write disable clears it
// - input sampled on clock rise, output shifted on clock fall
module sfep_top import sfep_pkg::*; #(
  parameter int unsigned CYC_SRW = SRW_CYC,
  parameter int unsigned CYC_PP = PP_CYC,
  parameter int unsigned CYC_CHE = CHE_CYC,
  parameter logic [7:0] OPC_RDSR = 8'h05,
  parameter logic [7:0] OPC_WRSR = 8'h01,
  parameter logic [7:0] OPC_WREN = 8'h06,
  parameter logic [7:0] OPC_WRDI = 8'h04,
  parameter logic [7:0] OPC_PD = 8'hb9,
  parameter logic [7:0] OPC_WAKE = 8'hab,
  parameter logic [7:0] ID_MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] ID_TYPE = 8'h11, // arbitrary value
  parameter logic [7:0] ID_CAP = 8'h12, // arbitrary value
  parameter logic [7:0] ID_RSVD = 8'h00
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic erase_go,
  output logic prog_go,
  output logic [PAGE_BITS-1:0] prog_page,
  output logic op_busy,
  output logic power_down,
  input wire logic buf_rd_en,
  input wire logic [7:0] buf_raddr,
  output logic [7:0] buf_rdata,
  output logic buf_rvalid
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  sfep_pins_t pins_in;
  sfep_pins_t s1_r;
  sfep_pins_t s2_r;
  logic sck_d_r;
  logic cs_d_r;
  assign pins_in = {sck, cs_n, si, hold_n, wp_n};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r <= PINS_RST;
      s2_r <= PINS_RST;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      s1_r <= pins_in;
      s2_r <= s1_r;
      sck_d_r <= s2_r.sck;
      cs_d_r <= s2_r.cs_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge decode; a frame must give the two flops time, so the serial clock
  // can run at a few MHz at most against this system clock
  logic hold_r;
  logic hold_nxt;
  logic [2:0] bit_cnt_r;
  logic [7:0] sh_r;
  wire sel = ~s2_r.cs_n;
  wire cs_rise = s2_r.cs_n & ~cs_d_r;
  wire rise_en = s2_r.sck & ~sck_d_r & sel & ~hold_r;
  wire fall_en = ~s2_r.sck & sck_d_r & sel & ~hold_r;
  wire byte_done = rise_en & (bit_cnt_r == 3'd7);
  wire bound_ok = (bit_cnt_r == 3'd0);
  wire [7:0] byte_val = {sh_r[6:0], s2_r.si};

  // hold: only while selected, entry needs the clock low
  assign hold_nxt = s2_r.cs_n ? 1'b0 :
                    hold_r ? ~s2_r.hold_n :
                    (~s2_r.hold_n & ~s2_r.sck);

  ////////////////////////////////////////////////////////////////////////////
  // command state
  sfep_state_t st_r;
  sfep_state_t st_nxt;
  sfep_pend_t pend_r;
  sfep_pend_t pend_nxt;
  logic [1:0] addr_cnt_r;
  logic [15:0] addr_r;
  logic [7:0] col_r;
  logic [PAGE_BITS-1:0] page_r;
  logic [1:0] id_idx_r;
  logic [1:0] id_nxt;
  logic out_id_r;
  logic out_id_nxt;
  logic [7:0] out_sr_r;
  logic out_en_r;
  logic out_load;
  logic [7:0] out_byte;
  logic addr_go;
  logic push_go;
  logic sr_go;
  logic [7:0] sr_data_r;
  logic [5:0] sr_bits_r;
  logic wel_r;
  logic wel_nxt;
  logic pd_r;
  logic overrun_r;
  logic prog_req_r;
  logic tmr_busy;
  logic tmr_done;
  wire busy_w = tmr_busy | prog_req_r;
  wire [7:0] stat_byte = {sr_bits_r, wel_r, busy_w};
  wire is_erase = (byte_val == OP_CHIP_ERASE_A) | (byte_val == OP_CHIP_ERASE_B);

  function automatic logic [7:0] id_byte(input logic [1:0] idx);
    case (idx)
      2'd0: id_byte = ID_MAKER;
      2'd1: id_byte = ID_TYPE;
      2'd2: id_byte = ID_CAP;
      default: id_byte = ID_RSVD;
    endcase
  endfunction

  // byte level sequencing; extra bytes after a fixed command void it
  always_comb begin
    st_nxt = st_r;
    pend_nxt = pend_r;
    id_nxt = id_idx_r;
    out_id_nxt = out_id_r;
    out_load = 1'b0;
    out_byte = 8'h00;
    addr_go = 1'b0;
    push_go = 1'b0;
    sr_go = 1'b0;
    case (st_r)
      ST_CMD: if (byte_done) begin
        st_nxt = ST_SKIP;
        if (pd_r) begin
          if (byte_val == OPC_WAKE) pend_nxt = PEND_WAKE;
        end else if (byte_val == OPC_RDSR) begin
          st_nxt = ST_OUT;
          out_id_nxt = 1'b0;
          out_load = 1'b1;
          out_byte = stat_byte;
        end else if (busy_w) begin
          st_nxt = ST_SKIP;
        end else if (byte_val == OP_READ_ID) begin
          st_nxt = ST_OUT;
          out_id_nxt = 1'b1;
          out_load = 1'b1;
          out_byte = id_byte(2'd0);
          id_nxt = 2'd1;
        end else if (is_erase & wel_r) begin
          pend_nxt = PEND_ERASE;
        end else if ((byte_val == OP_PAGE_PROG) & wel_r) begin
          st_nxt = ST_ADDR;
        end else if ((byte_val == OPC_WRSR) & wel_r) begin
          st_nxt = ST_SRW;
        end else if (byte_val == OPC_WREN) begin
          pend_nxt = PEND_WEN;
        end else if (byte_val == OPC_WRDI) begin
          pend_nxt = PEND_WDIS;
        end else if (byte_val == OPC_PD) begin
          pend_nxt = PEND_PD;
        end
      end
      ST_ADDR: if (byte_done & (addr_cnt_r == 2'd2)) begin
        st_nxt = ST_DATA;
        addr_go = 1'b1;
      end
      ST_DATA: if (byte_done) begin
        push_go = 1'b1;
        pend_nxt = PEND_PROG;
      end
      ST_SRW: if (byte_done) begin
        st_nxt = ST_SRW2;
        pend_nxt = PEND_SRW;
        sr_go = 1'b1;
      end
      ST_SRW2: if (byte_done) begin
        st_nxt = ST_SKIP;
        pend_nxt = PEND_NONE;
      end
      ST_OUT: if (byte_done) begin
        out_load = 1'b1;
        out_byte = out_id_r ? id_byte(id_idx_r) : stat_byte;
        id_nxt = 2'(id_idx_r + 2'd1);
      end
      ST_SKIP: if (byte_done) pend_nxt = PEND_NONE;
      default: st_nxt = ST_SKIP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution at chip select rise, only on a byte boundary
  wire exec_ok = cs_rise & bound_ok & ~overrun_r;
  wire go_erase = exec_ok & (pend_r == PEND_ERASE);
  wire go_prog = exec_ok & (pend_r == PEND_PROG);
  wire sr_locked = sr_data_r[STATUS_LOCK_BIT] & sr_bits_r[STATUS_LOCK_BIT - 2] & ~s2_r.wp_n;
  wire go_srw = exec_ok & (pend_r == PEND_SRW) & ~sr_locked;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic word_vld_r;
  sfep_byte_t word_r;
  sfep_byte_t fifo_out;
  // program waits until every byte has landed in the page buffer
  wire prog_start = prog_req_r & ~fifo_out_valid & ~word_vld_r;
  wire tmr_start = go_erase | go_srw | prog_start;
  wire [31:0] tmr_cyc = go_erase ? CYC_CHE : go_srw ? CYC_SRW : CYC_PP;

  // a write enable cannot land while busy, so no clash with the done clear
  assign wel_nxt = (exec_ok & (pend_r == PEND_WEN)) ? 1'b1 :
                   (tmr_done | (exec_ok & (pend_r == PEND_WDIS))) ? 1'b0 : wel_r;

  sfep_timer u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(tmr_start),
    .cycles(tmr_cyc),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // serial shift, framing and address capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hold_r <= 1'b0;
      bit_cnt_r <= 3'd0;
      sh_r <= 8'h00;
      st_r <= ST_CMD;
      pend_r <= PEND_NONE;
      addr_cnt_r <= 2'd0;
      addr_r <= 16'h0000;
    end else begin
      hold_r <= hold_nxt;
      if (cs_rise) begin
        bit_cnt_r <= 3'd0;
        st_r <= ST_CMD;
        pend_r <= PEND_NONE;
        addr_cnt_r <= 2'd0;
      end else begin
        if (rise_en) bit_cnt_r <= 3'(bit_cnt_r + 3'd1);
        if (rise_en) sh_r <= byte_val;
        st_r <= st_nxt;
        pend_r <= pend_nxt;
        if ((st_r == ST_ADDR) & byte_done) addr_cnt_r <= 2'(addr_cnt_r + 2'd1);
        if ((st_r == ST_ADDR) & byte_done) addr_r <= {addr_r[7:0], byte_val};
      end
    end
  end

  // page pointer; upper address bits are dropped and the column wraps
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      col_r <= 8'h00;
      page_r <= '0;
    end else if (addr_go) begin
      col_r <= byte_val;
      page_r <= addr_r[PAGE_BITS-1:0];
    end else if (push_go) begin
      col_r <= 8'(col_r + 8'd1);
    end
  end

  // output shifter: loaded on a byte end, shifted on each falling clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_sr_r <= 8'h00;
      out_en_r <= 1'b0;
      so <= 1'b0;
      id_idx_r <= 2'd0;
      out_id_r <= 1'b0;
    end else if (cs_rise) begin
      out_en_r <= 1'b0;
      id_idx_r <= 2'd0;
    end else begin
      id_idx_r <= id_nxt;
      out_id_r <= out_id_nxt;
      if (out_load) out_sr_r <= out_byte;
      else if (fall_en) out_sr_r <= {out_sr_r[6:0], 1'b0};
      if (out_load) out_en_r <= 1'b1;
      if (fall_en) so <= out_sr_r[7];
    end
  end
  assign so_oe = out_en_r & sel & ~hold_r;

  // device state: latches, power mode, pending program
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wel_r <= 1'b0;
      pd_r <= 1'b0;
      sr_data_r <= 8'h00;
      sr_bits_r <= STATUS_BITS_RST;
      prog_req_r <= 1'b0;
      erase_go <= 1'b0;
      prog_go <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
      if (exec_ok & (pend_r == PEND_PD)) pd_r <= 1'b1;
      else if (exec_ok & (pend_r == PEND_WAKE)) pd_r <= 1'b0;
      if (sr_go) sr_data_r <= byte_val;
      if (go_srw) sr_bits_r <= sr_data_r[7:2];
      if (go_prog) prog_req_r <= 1'b1;
      else if (prog_start) prog_req_r <= 1'b0;
      erase_go <= go_erase;
      prog_go <= prog_start;
    end
  end
  assign prog_page = page_r;
  assign op_busy = busy_w;
  assign power_down = pd_r;

  ////////////////////////////////////////////////////////////////////////////
  // data path: staging word, fifo, page buffer
  // a byte finishing while the staging word is still full and the fifo refuses it poisons the frame
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_vld_r <= 1'b0;
      word_r <= '0;
      overrun_r <= 1'b0;
    end else begin
      if (push_go) word_r <= '{col: col_r, data: byte_val};
      if (push_go) word_vld_r <= 1'b1;
      else if (fifo_in_ready) word_vld_r <= 1'b0;
      if (cs_rise) overrun_r <= 1'b0;
      else if (push_go & word_vld_r & ~fifo_in_ready) overrun_r <= 1'b1;
    end
  end

  sfep_fifo #(
    .WIDTH($bits(sfep_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(word_vld_r),
    .in_ready(fifo_in_ready),
    .in_data(word_r),
    .out_valid(fifo_out_valid),
    .out_ready(~buf_rd_en),
    .out_data(fifo_out)
  );

  // buffer port is shared; the core's reads win and stall the drain
  logic [7:0] buf_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r;
  wire buf_wr = fifo_out_valid & ~buf_rd_en;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask_r <= '0;
      buf_rdata <= 8'h00;
      buf_rvalid <= 1'b0;
    end else begin
      if (addr_go) mask_r <= '0;
      else if (buf_wr) mask_r[fifo_out.col] <= 1'b1;
      if (buf_rd_en) buf_rdata <= buf_mem[buf_raddr];
      if (buf_rd_en) buf_rvalid <= mask_r[buf_raddr];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (buf_wr) buf_mem[fifo_out.col] <= fifo_out.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence erase_taken_s;
    exec_ok && (pend_r == PEND_ERASE);
  endsequence
  sequence busy_run_s;
    tmr_busy && stat_byte[STATUS_BUSY_BIT];
  endsequence
  erase_start_a: assert property (erase_taken_s |=> erase_go ##0 busy_run_s [*4])
    else $error("erase did not start with busy");
  id_busy_a: assert property (byte_done && (st_r == ST_CMD) && !pd_r && busy_w &&
    (byte_val == OP_READ_ID) |=> (st_r == ST_SKIP) && !out_en_r)
    else $error("id read taken while busy");
  id_wrap_a: assert property ((st_r == ST_OUT) && out_id_r && byte_done && (id_idx_r == 2'd3)
    |=> (id_idx_r == 2'd0) && (out_sr_r == ID_RSVD))
    else $error("id sequence did not wrap");
  hold_enter_a: assert property (sel && !hold_r && !s2_r.hold_n && !s2_r.sck |=> hold_r)
    else $error("hold not entered");
  cs_reset_a: assert property (cs_rise |=> !hold_r && (st_r == ST_CMD) && (bit_cnt_r == 3'd0))
    else $error("select rise did not reset interface");
  hold_float_a: assert property (hold_r |-> !so_oe && !rise_en && !fall_en)
    else $error("output driven in hold");
  // the shifter, bit count and output bit must not move while suspended
  hold_freeze_a: assert property (hold_r && !cs_rise |=>
    $stable(bit_cnt_r) && $stable(out_sr_r) && $stable(so))
    else $error("serial state moved in hold");
  partial_drop_a: assert property (cs_rise && !bound_ok |=> !erase_go && !$rose(prog_req_r)
    && !$rose(tmr_busy))
    else $error("partial frame executed");
  srw_long_a: assert property ((st_r == ST_SRW2) && byte_done |=> (pend_r == PEND_NONE))
    else $error("long status write kept");
  wel_clear_a: assert property (tmr_done |=> !wel_r)
    else $error("write enable not cleared");
  erase_len_a: assert property ($rose(erase_go) |-> ##1 (u_timer.cnt_r == CYC_CHE - 1))
    else $error("erase time wrong");
endmodule
`default_nettype wire
